// ===== pmrc_pkg.sv
// Purpose: Constants and types for the pin function, reset and irq block
// Assumes: APB slave on pclk at 10 MHz, 32-bit data, one word per register
// Notes: One rule per line below, tag first
package pmrc_pkg;
   localparam logic [7:0] PMRC_CFG_A_OFS = 8'h00;
   localparam logic [7:0] PMRC_CFG_B_OFS = 8'h04;
   localparam logic [7:0] PMRC_STATE_OFS = 8'h08;
   localparam logic [7:0] PMRC_TB_OFS = 8'h0c;
   localparam logic [7:0] PMRC_IRQ_ST_OFS = 8'h10;
   localparam logic [7:0] PMRC_IRQ_EN_OFS = 8'h14;
   localparam logic [2:0] PMRC_SEL_HIZ = 3'h0;
   localparam logic [2:0] PMRC_SEL_LOW = 3'h1;
   localparam logic [2:0] PMRC_SEL_HIGH = 3'h2;
   localparam logic [2:0] PMRC_SEL_ALT = 3'h3;
   localparam logic [2:0] PMRC_SEL_REF = 3'h4;
   localparam logic [2:0] PMRC_SEL_EG1 = 3'h6;
   localparam logic [2:0] PMRC_SEL_EVT = 3'h7;
   localparam int PMRC_PIN_N = 9;
   localparam int PMRC_BIDIR_N = 7;
   localparam int PMRC_SEL_A_W = 15;
   localparam int PMRC_SEL_B_W = 12;
   localparam int PMRC_GRST_BIT = 15;
   localparam int PMRC_E13_LSB = 12;
   localparam int PMRC_E47_LSB = 14;
   localparam int PMRC_LATCH_LSB = 8;
   localparam int PMRC_SUM_BIT = 15;
   localparam int PMRC_TB_RST_BIT = 0;
   localparam int PMRC_TB_PWDN_BIT = 1;
   localparam int PMRC_REF_PLL_POWER_DOWN_BIT = 2;
   localparam int PMRC_SYNC_W = 13;
   localparam int PMRC_STRAP_PIN = 2;
   localparam logic [1:0] PMRC_EDGE_RST = 2'h1;
   localparam logic [26:0] PMRC_SEL_RST = 27'h0;

   typedef enum logic [1:0] {
      PMRC_ST_W1 = 2'b00,
      PMRC_ST_W2 = 2'b01,
      PMRC_ST_CAPT = 2'b10,
      PMRC_ST_RUN = 2'b11
   } pmrc_strap_t;

   typedef struct packed {
      logic oe;
      logic dout;
   } pmrc_drive_t;
endpackage

// ===== pmrc_sync.sv
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Bits are independent levels; no bus coherence is implied
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
module pmrc_sync #(
   parameter int W = 1
) (
   input wire logic clk, // Sampling clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== pmrc_top.sv
// Purpose: Pin function select, edge latches, resets and irq summary
// Assumes: Fast clocks are sampled at pclk, so routed clocks are aliased
// Notes: Zero-wait APB; reads of the state register clear edge latches
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module pmrc_top
   import pmrc_pkg::*;
(
   input wire logic pclk, // APB clock, 10 MHz
   input wire logic presetn, // Reset pin, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic out_only_pin_a_in, // Strap level on pin A
   output logic [1:0] out_only_out, // Pin A/B level
   output logic [1:0] out_only_oe, // Pin A/B drive enable
   input wire logic [6:0] bidir_pin_in, // Bidir pins 1..7 level
   output logic [6:0] bidir_pin_out, // Bidir pins output level
   output logic [6:0] bidir_pin_oe, // Bidir pins drive enable
   input wire logic ref_clk_125, // PLL 125MHz clock
   input wire logic timebase_clock_out, // Timebase output clock
   input wire logic event_gen_1, // Event generator 1
   input wire logic event_gen_2, // Event generator 2
   input wire logic ref_pll_power_down, // PLL power-down pin
   input wire logic test_port_reset_n, // Test port reset, active low
   output logic test_rst_n_o, // Test logic reset, active low
   output logic timebase_reset_o, // Timebase reset pulse
   output logic timebase_power_down_o, // Timebase disable level
   output logic pll_bypass_o, // PLL down and bypassed
   output logic pll_reset_o, // PLL reset pulse
   output logic irq_summary_o // Summary of enabled status
);
   logic soft_rst_r;
   logic rst_n;
   logic [PMRC_SYNC_W-1:0] sync_q;
   logic [6:0] lvl;
   logic oo_a_s, ref_s, tbc_s, eg1_s, eg2_s, pll_pin_s;
   logic [26:0] sel_r;
   logic [1:0] edge13_r, edge47_r;
   logic tb_pwdn_r, ref_pll_power_down_r;
   logic [6:0] irq_en_r, latch_r, prev_r, hit;
   logic irq_sum_r;
   logic tb_rst_r, pll_rst_r, pll_bypass_r;
   logic [1:0] trst_r;
   pmrc_strap_t strap_r;
   pmrc_drive_t drive_r [PMRC_PIN_N];
   logic setup, access, wr, rd_clr;
   logic wr_a, wr_b, wr_tb, wr_en;
   logic [31:0] rd_val;
   logic rd_bad;

   // Soft reset comes from a flop, so the derived reset is glitch free
   assign rst_n = presetn & ~soft_rst_r;

   pmrc_sync #(.W(PMRC_SYNC_W)) u_sync (
      .clk(pclk),
      .rst_n(rst_n),
      .d({ref_pll_power_down, event_gen_2, event_gen_1,
          timebase_clock_out, ref_clk_125, out_only_pin_a_in,
          bidir_pin_in}),
      .q(sync_q)
   );
   assign lvl = sync_q[6:0];
   assign oo_a_s = sync_q[7];
   assign ref_s = sync_q[8];
   assign tbc_s = sync_q[9];
   assign eg1_s = sync_q[10];
   assign eg2_s = sync_q[11];
   assign pll_pin_s = sync_q[12];

   // APB decode; writes land at the access edge with pready high
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign wr_a = wr & (paddr == PMRC_CFG_A_OFS);
   assign wr_b = wr & (paddr == PMRC_CFG_B_OFS);
   assign wr_tb = wr & (paddr == PMRC_TB_OFS);
   assign wr_en = wr & (paddr == PMRC_IRQ_EN_OFS);
   assign rd_clr = access & ~pwrite & (paddr == PMRC_STATE_OFS);

   always_comb begin
      rd_val = 32'h0;
      rd_bad = 1'b0;
      case (paddr)
         PMRC_CFG_A_OFS: rd_val[PMRC_SEL_A_W-1:0] = sel_r[14:0];
         PMRC_CFG_B_OFS: begin
            rd_val[PMRC_SEL_B_W-1:0] = sel_r[26:15];
            rd_val[PMRC_E13_LSB+:2] = edge13_r;
            rd_val[PMRC_E47_LSB+:2] = edge47_r;
         end
         PMRC_STATE_OFS: begin
            rd_val[6:0] = lvl;
            rd_val[PMRC_LATCH_LSB+:7] = latch_r;
         end
         PMRC_TB_OFS: begin
            rd_val[PMRC_TB_PWDN_BIT] = tb_pwdn_r;
            rd_val[PMRC_REF_PLL_POWER_DOWN_BIT] = ref_pll_power_down_r;
         end
         PMRC_IRQ_ST_OFS: begin
            rd_val[6:0] = latch_r;
            rd_val[PMRC_SUM_BIT] = irq_sum_r;
         end
         PMRC_IRQ_EN_OFS: rd_val[6:0] = irq_en_r;
         default: rd_bad = 1'b1;
      endcase
   end

   // Data is captured in the setup cycle, so the access phase has no wait
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & rd_bad;
         if (setup && !pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // Only the pin resets this flop; it clears itself one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_a & pwdata[PMRC_GRST_BIT];
      end
   end

   // Strap on pin A is read once both sync stages hold valid data
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_r <= PMRC_ST_W1;
      end else begin
         case (strap_r)
            PMRC_ST_W1: strap_r <= PMRC_ST_W2;
            PMRC_ST_W2: strap_r <= PMRC_ST_CAPT;
            PMRC_ST_CAPT: strap_r <= PMRC_ST_RUN;
            PMRC_ST_RUN: strap_r <= PMRC_ST_RUN;
            default: strap_r <= PMRC_ST_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= PMRC_SEL_RST;
         edge13_r <= PMRC_EDGE_RST;
         edge47_r <= PMRC_EDGE_RST;
      end else begin
         if (strap_r == PMRC_ST_CAPT && oo_a_s) begin
            sel_r[3*PMRC_STRAP_PIN+:3] <= PMRC_SEL_REF;
         end
         if (wr_a) begin
            sel_r[14:0] <= pwdata[PMRC_SEL_A_W-1:0];
         end
         if (wr_b) begin
            sel_r[26:15] <= pwdata[PMRC_SEL_B_W-1:0];
            edge13_r <= pwdata[PMRC_E13_LSB+:2];
            edge47_r <= pwdata[PMRC_E47_LSB+:2];
         end
      end
   end

   // Timebase and PLL controls; a cleared power-down pulses its reset
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         tb_pwdn_r <= 1'b0;
         ref_pll_power_down_r <= 1'b0;
         tb_rst_r <= 1'b0;
         pll_rst_r <= 1'b0;
         pll_bypass_r <= 1'b0;
      end else begin
         tb_rst_r <= wr_tb & (pwdata[PMRC_TB_RST_BIT] |
            (tb_pwdn_r & ~pwdata[PMRC_TB_PWDN_BIT]));
         if (wr_tb) begin
            tb_pwdn_r <= pwdata[PMRC_TB_PWDN_BIT];
            ref_pll_power_down_r <= pwdata[PMRC_REF_PLL_POWER_DOWN_BIT];
         end
         pll_bypass_r <= ref_pll_power_down_r | pll_pin_s;
         pll_rst_r <= pll_bypass_r & ~(ref_pll_power_down_r | pll_pin_s);
      end
   end
   assign timebase_reset_o = tb_rst_r;
   assign timebase_power_down_o = tb_pwdn_r;
   assign pll_bypass_o = pll_bypass_r;
   assign pll_reset_o = pll_rst_r;

   // Test logic reset stays clear of the main reset sources
   always_ff @(posedge pclk or negedge test_port_reset_n) begin
      if (!test_port_reset_n) begin
         trst_r <= 2'b00;
      end else begin
         trst_r <= {trst_r[0], 1'b1};
      end
   end
   assign test_rst_n_o = trst_r[1];

   // Edge latches; a new edge wins over a clearing read
   generate
      for (genvar j = 0; j < PMRC_BIDIR_N; j++) begin : g_edge
         logic [1:0] es;
         assign es = (j < 3) ? edge13_r : edge47_r;
         // No edges until prev_r holds a real level after reset
         assign hit[j] = (strap_r == PMRC_ST_RUN) &
                         ((es[0] & lvl[j] & ~prev_r[j]) |
                          (es[1] & ~lvl[j] & prev_r[j]));
      end
   endgenerate

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 7'h0;
         latch_r <= 7'h0;
         irq_en_r <= 7'h0;
         irq_sum_r <= 1'b0;
      end else begin
         prev_r <= lvl;
         // Only bits this read reported clear, so later edges survive
         latch_r <= (latch_r & ~(prdata[PMRC_LATCH_LSB+:7] & {7{rd_clr}}))
            | hit;
         if (wr_en) begin
            irq_en_r <= pwdata[6:0];
         end
         irq_sum_r <= |(latch_r & irq_en_r);
      end
   end
   assign irq_summary_o = irq_sum_r;

   // Pin groups: 0,2,4 carry irq; 1,3 carry clock; 5..8 are wide
   function automatic pmrc_drive_t pin_fn(input logic [2:0] s,
      input int i, input logic irq, input logic rf, input logic tc,
      input logic e1, input logic e2);
      pmrc_drive_t d;
      logic grp_irq;
      logic wide;
      d = '{oe: 1'b0, dout: 1'b0};
      grp_irq = (i == 0) || (i == 2) || (i == 4);
      wide = (i >= 5);
      case (s)
         PMRC_SEL_HIZ: d = '{oe: 1'b0, dout: 1'b0};
         PMRC_SEL_LOW: d = '{oe: 1'b1, dout: 1'b0};
         PMRC_SEL_HIGH: d = '{oe: 1'b1, dout: 1'b1};
         PMRC_SEL_ALT: begin
            if (grp_irq && i == 0) begin
               d = '{oe: 1'b1, dout: ~irq};
            end else if (grp_irq) begin
               d = '{oe: irq, dout: 1'b0};
            end else begin
               d = '{oe: 1'b1, dout: tc};
            end
         end
         PMRC_SEL_REF: d = '{oe: 1'b1, dout: rf};
         PMRC_SEL_EG1: begin
            if (wide) begin
               d = '{oe: 1'b1, dout: e1};
            end
         end
         PMRC_SEL_EVT: d = '{oe: 1'b1,
            dout: (grp_irq ? e1 : e2)};
         // Reserved codes leave the pin undriven
         default: d = '{oe: 1'b0, dout: 1'b0};
      endcase
      return d;
   endfunction

   generate
      for (genvar g = 0; g < PMRC_PIN_N; g++) begin : g_pin
         always_ff @(posedge pclk or negedge rst_n) begin
            if (!rst_n) begin
               drive_r[g] <= '{oe: 1'b0, dout: 1'b0};
            end else begin
               drive_r[g] <= pin_fn(sel_r[3*g+:3], g, irq_sum_r,
                  ref_s, tbc_s, eg1_s, eg2_s);
            end
         end
      end
      for (genvar k = 0; k < PMRC_BIDIR_N; k++) begin : g_bout
         assign bidir_pin_out[k] = drive_r[k+2].dout;
         assign bidir_pin_oe[k] = drive_r[k+2].oe;
      end
   endgenerate
   assign out_only_out = {drive_r[1].dout, drive_r[0].dout};
   assign out_only_oe = {drive_r[1].oe, drive_r[0].oe};

   property p_hiz;
      @(posedge pclk) disable iff (!rst_n)
      sel_r[5:3] == PMRC_SEL_HIZ |=> !out_only_oe[1];
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("pin B driven while hi-Z selected");

   property p_low;
      @(posedge pclk) disable iff (!rst_n)
      sel_r[17:15] == PMRC_SEL_LOW |=> bidir_pin_oe[3] && !bidir_pin_out[3];
   endproperty
   a_low: assert property (p_low)
      else $error("bidir 4 not driven low");

   property p_irq_od;
      @(posedge pclk) disable iff (!rst_n)
      sel_r[8:6] == PMRC_SEL_ALT |=>
         bidir_pin_oe[0] == $past(irq_sum_r) && !bidir_pin_out[0];
   endproperty
   a_irq_od: assert property (p_irq_od)
      else $error("open-drain irq on bidir 1 wrong");

   property p_irq_pp;
      @(posedge pclk) disable iff (!rst_n)
      sel_r[2:0] == PMRC_SEL_ALT |=>
         out_only_oe[0] && out_only_out[0] == !$past(irq_sum_r);
   endproperty
   a_irq_pp: assert property (p_irq_pp)
      else $error("pin A does not follow summary");

   property p_hold;
      @(posedge pclk) disable iff (!rst_n)
      latch_r[0] && !rd_clr |=> latch_r[0];
   endproperty
   a_hold: assert property (p_hold)
      else $error("edge latch lost without a read");

   property p_edge;
      @(posedge pclk) disable iff (!rst_n)
      strap_r == PMRC_ST_RUN && edge47_r[0] && lvl[4] && !prev_r[4] |=>
         latch_r[4] ##1 (irq_sum_r || !irq_en_r[4]);
   endproperty
   a_edge: assert property (p_edge)
      else $error("rising edge on bidir 5 not latched");

   property p_sum;
      @(posedge pclk) disable iff (!rst_n)
      (latch_r & irq_en_r) == 7'h0 |=> !irq_sum_r;
   endproperty
   a_sum: assert property (p_sum)
      else $error("summary set with nothing enabled");

   property p_tbrst;
      @(posedge pclk) disable iff (!rst_n)
      wr_tb && pwdata[PMRC_TB_RST_BIT] |=> tb_rst_r ##1 !tb_rst_r;
   endproperty
   a_tbrst: assert property (p_tbrst)
      else $error("timebase reset is not a single pulse");

   property p_pwdn;
      @(posedge pclk) disable iff (!rst_n)
      wr_tb && tb_pwdn_r && !pwdata[PMRC_TB_PWDN_BIT] |=>
         tb_rst_r && !tb_pwdn_r;
   endproperty
   a_pwdn: assert property (p_pwdn)
      else $error("power-up without reset pulse");

   property p_soft;
      @(posedge pclk) disable iff (!presetn)
      wr_a && pwdata[PMRC_GRST_BIT] |=> ##1 sel_r == PMRC_SEL_RST;
   endproperty
   a_soft: assert property (p_soft)
      else $error("global reset bit did not reset config");
endmodule

// ===== pmrc_bench.sv
// Purpose: Self-checking bench for the pin function, reset and irq block
// Assumes: Zero-wait APB slave; routed sources held static while checked
// Notes: Inputs change by NBA on rising edges; one task per scenario
`timescale 1ns/1ns
module pmrc_bench
   import pmrc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pin_a_in, rf, tc, e1, e2, pll_pin, tp_rst_n;
   logic [1:0] oo_out, oo_oe;
   logic [6:0] bi_in, bi_out, bi_oe;
   logic test_rst_n, tb_rst, tb_pwdn, bypass, pll_rst, irq;
   int failures, checks, tb_pulses, pll_pulses;

   pmrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_only_pin_a_in(pin_a_in), .out_only_out(oo_out),
      .out_only_oe(oo_oe), .bidir_pin_in(bi_in), .bidir_pin_out(bi_out),
      .bidir_pin_oe(bi_oe), .ref_clk_125(rf), .timebase_clock_out(tc),
      .event_gen_1(e1), .event_gen_2(e2), .ref_pll_power_down(pll_pin),
      .test_port_reset_n(tp_rst_n), .test_rst_n_o(test_rst_n),
      .timebase_reset_o(tb_rst), .timebase_power_down_o(tb_pwdn),
      .pll_bypass_o(bypass), .pll_reset_o(pll_rst), .irq_summary_o(irq));

   // Bus rides on the block clock, so it slows with it
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Pulse outputs stand one cycle, so they are counted every edge
   always @(posedge pclk) begin
      if (tb_rst === 1'b1) tb_pulses++;
      if (pll_rst === 1'b1) pll_pulses++;
   end

   task complete_run;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task pchk(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask

   task cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // Holds the request until pready is seen high at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Expected {oe,out}; g 0 irq group, 1 pin B group, 2 pins 4-7
   function automatic logic [1:0] drv(input int g, input int c,
                                      input logic [3:0] s);
      case (c)
         0, 5: drv = 2'b00;
         1: drv = 2'b10;
         2: drv = 2'b11;
         3: drv = (g == 0) ? 2'b11 : {1'b1, s[2]};
         4: drv = {1'b1, s[3]};
         6: drv = (g == 2) ? {1'b1, s[1]} : 2'b00;
         default: drv = (g == 0) ? {1'b1, s[1]} : {1'b1, s[0]};
      endcase
   endfunction

   task test_reset_vals;
      chk({18'h0, oo_oe, bi_oe, tb_rst, tb_pwdn, bypass, pll_rst, irq}, 0);
      apb(1'b0, PMRC_CFG_A_OFS, 0);
      chk(q, 32'h0);
      apb(1'b0, PMRC_CFG_B_OFS, 0);
      chk(q, 32'h5000);
      apb(1'b0, PMRC_IRQ_EN_OFS, 0);
      chk(q, 32'h0);
      $display("reset values done");
   endtask

   task test_select;
      logic [3:0] s;
      for (int p = 0; p < 2; p++) begin
         s = (p == 0) ? 4'ha : 4'h5;
         @(posedge pclk);
         {rf, tc, e1, e2} <= s;
         for (int c = 0; c < 8; c++) begin
            if (c == 5) continue;
            apb(1'b1, PMRC_CFG_A_OFS,
               (c == 6) ? 32'h0 : 32'(c) | (32'(c) << 3));
            apb(1'b1, PMRC_CFG_B_OFS, 32'h5000 | 32'(c));
            cyc(5);
            pchk({oo_oe[0], oo_out[0]}, drv(0, c, s));
            pchk({oo_oe[1], oo_out[1]}, drv(1, c, s));
            pchk({bi_oe[3], bi_out[3]}, drv(2, c, s));
         end
      end
      $display("select codes done");
   endtask

   task test_edges_irq;
      apb(1'b1, PMRC_CFG_A_OFS, 32'h30c3);
      apb(1'b1, PMRC_CFG_B_OFS, 32'h5000);
      apb(1'b1, PMRC_IRQ_EN_OFS, 32'h2);
      apb(1'b0, PMRC_STATE_OFS, 0);
      @(posedge pclk);
      bi_in <= 7'h02;
      cyc(8);
      chk({31'h0, irq}, 32'h1);
      chk({30'h0, oo_oe[0], oo_out[0]}, 32'h2);
      chk({30'h0, bi_oe[2], bi_out[2]}, 32'h2);
      chk({30'h0, bi_oe[0], bi_out[0]}, 32'h2);
      apb(1'b0, PMRC_IRQ_ST_OFS, 0);
      chk(q, 32'h8002);
      apb(1'b0, PMRC_STATE_OFS, 0);
      chk(q, 32'h0202);
      cyc(4);
      chk({31'h0, irq}, 32'h0);
      chk({30'h0, oo_oe[0], oo_out[0]}, 32'h3);
      chk({31'h0, bi_oe[2]}, 32'h0);
      apb(1'b0, PMRC_STATE_OFS, 0);
      chk(q, 32'h0002);
      apb(1'b1, PMRC_CFG_B_OFS, 32'h6000);
      @(posedge pclk);
      bi_in <= 7'h11;
      cyc(8);
      apb(1'b0, PMRC_STATE_OFS, 0);
      chk(q, 32'h1211);
      @(posedge pclk);
      bi_in <= 7'h00;
      cyc(8);
      apb(1'b0, PMRC_STATE_OFS, 0);
      chk(q, 32'h0100);
      apb(1'b1, PMRC_CFG_A_OFS, 0);
      $display("edges and irq done");
   endtask

   task test_timebase;
      tb_pulses = 0;
      pll_pulses = 0;
      apb(1'b1, PMRC_TB_OFS, 32'h1);
      cyc(4);
      chk(32'(tb_pulses), 32'h1);
      apb(1'b1, PMRC_TB_OFS, 32'h2);
      cyc(3);
      chk({31'h0, tb_pwdn}, 32'h1);
      apb(1'b0, PMRC_TB_OFS, 0);
      chk(q, 32'h2);
      apb(1'b1, PMRC_TB_OFS, 32'h0);
      cyc(4);
      chk(32'(tb_pulses), 32'h2);
      apb(1'b1, PMRC_TB_OFS, 32'h4);
      cyc(3);
      chk({31'h0, bypass}, 32'h1);
      apb(1'b1, PMRC_TB_OFS, 32'h0);
      cyc(4);
      chk(32'(pll_pulses), 32'h1);
      @(posedge pclk);
      pll_pin <= 1'b1;
      cyc(5);
      chk({31'h0, bypass}, 32'h1);
      pll_pin <= 1'b0;
      cyc(5);
      chk({31'h0, bypass}, 32'h0);
      chk(32'(pll_pulses), 32'h2);
      $display("timebase and pll done");
   endtask

   task test_port_and_map;
      apb(1'b1, PMRC_CFG_A_OFS, 32'h2);
      @(posedge pclk);
      tp_rst_n <= 1'b0;
      cyc(2);
      chk({31'h0, test_rst_n}, 32'h0);
      tp_rst_n <= 1'b1;
      cyc(4);
      chk({31'h0, test_rst_n}, 32'h1);
      apb(1'b0, PMRC_CFG_A_OFS, 0);
      chk(q, 32'h2);
      apb(1'b1, 8'h18, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h18, 0);
      chk({err, q[30:0]}, 32'h8000_0000);
      $display("test port and map done");
   endtask

   task test_global_reset;
      apb(1'b1, PMRC_IRQ_EN_OFS, 32'h7f);
      apb(1'b1, PMRC_CFG_A_OFS, 32'h8012);
      cyc(4);
      apb(1'b0, PMRC_CFG_A_OFS, 0);
      chk(q, 32'h0);
      apb(1'b0, PMRC_IRQ_EN_OFS, 0);
      chk(q, 32'h0);
      chk({30'h0, oo_oe}, 32'h0);
      $display("global reset done");
   endtask

   task test_strap;
      @(posedge pclk);
      presetn <= 1'b0;
      pin_a_in <= 1'b1;
      cyc(100);
      chk({22'h0, test_rst_n, bi_oe, oo_oe}, 32'h200);
      presetn <= 1'b1;
      cyc(6);
      chk({31'h0, bi_oe[0]}, 32'h1);
      apb(1'b0, PMRC_CFG_A_OFS, 0);
      chk(q & 32'h1c0, 32'h100);
      $display("strap done");
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pin_a_in, rf, tc, e1, e2, pll_pin} = '0;
      bi_in = 7'h00;
      tp_rst_n = 1'b1;
      presetn = 1'b0;
      failures = 0;
      checks = 0;
      tb_pulses = 0;
      pll_pulses = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cyc(5);
      test_reset_vals;
      test_select;
      test_edges_irq;
      test_timebase;
      test_port_and_map;
      test_global_reset;
      test_strap;
      complete_run;
   end

   // About 430 cycles are needed; the margin covers slow answers
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      complete_run;
   end
endmodule
